// ===== include/mfcr_defines.svh
// Purpose: register offsets, field positions, reset values and timing counts of the modem front end register bank
// Assumes: 100 MHz system clock, 8-bit registers at printed offsets
// Notes: definitions only
`ifndef MFCR_DEFINES_SVH
`define MFCR_DEFINES_SVH

`define MFCR_ADDR_W 4
`define MFCR_OFS_FILTER_SEL 4'h4
`define MFCR_OFS_TUNE_TARGET 4'h5
`define MFCR_OFS_GAIN_ADJ 4'h6
`define MFCR_OFS_TX_SET 4'h7
`define MFCR_OFS_RX_CLK_SET 4'h8
`define MFCR_OFS_REVISION 4'hf

`define MFCR_RST_FILTER_SEL 8'h01
`define MFCR_RST_TUNE_TARGET 8'h80
`define MFCR_RST_GAIN_ADJ 8'h00
`define MFCR_RST_TX_SET 8'h10
`define MFCR_RST_RX_CLK_SET 8'h00
// revision code value is arbitrary
`define MFCR_REVISION_CODE 8'h00

// filter selection register fields
`define MFCR_FS_BYPASS 0
`define MFCR_FS_ONE_POLE 1
`define MFCR_FS_WIDEBAND 2
`define MFCR_FS_FAST_ADC 3
`define MFCR_FS_HPF_BYPASS 4
`define MFCR_FS_OFFSET_CORR 5
`define MFCR_FS_CAL_BUSY 6
`define MFCR_FS_UPD_DISABLE 7
`define MFCR_FS_WR_MASK 8'h9f

// gain adjust register fields
`define MFCR_GA_GAIN_MSB 4
`define MFCR_GA_SRC_REG 5
`define MFCR_GA_BOOST_LVL 6
`define MFCR_GA_BOOST_INV 7
`define MFCR_GAIN_MAX 5'h15
`define MFCR_GAIN_WIDE_CAP 5'h12
`define MFCR_GAIN_CODES 22

// transmit settings fields
`define MFCR_TX_TWOS 0
`define MFCR_TX_FALL 1
`define MFCR_TX_INTERP_LSB 4
`define MFCR_TX_WR_MASK 8'hf3
`define MFCR_INTERP_LPF 4'h1
`define MFCR_INTERP_BYPASS 4'h2
`define MFCR_INTERP_BPF 4'h5

// receive and clock output fields
`define MFCR_RX_TWOS 0
`define MFCR_RX_FALL 1
`define MFCR_RX_TRISTATE 3
`define MFCR_CKA_OFF 4
`define MFCR_CKB_OFF 5
`define MFCR_CKA_OSC 6
`define MFCR_CKB_DIV4 7
`define MFCR_RX_WR_MASK 8'hfb

// clock source multiplier field (lives in a register outside this bank)
`define MFCR_MULT_X1 2'h0
`define MFCR_MULT_X2 2'h1
`define MFCR_MULT_X4 2'h2
`define MFCR_MULT_X8 2'h3

// timing
`define MFCR_CLK_HZ 100000000
`define MFCR_CAL_TIME_US 500
`define MFCR_CAL_CYCLES ((`MFCR_CAL_TIME_US * (`MFCR_CLK_HZ / 1000000)))
`define MFCR_PERIOD_S 2
`define MFCR_PERIOD_CYCLES (`MFCR_PERIOD_S * `MFCR_CLK_HZ)
`define MFCR_OFFSET_TIME_US 10
`define MFCR_OFFSET_CYCLES ((`MFCR_OFFSET_TIME_US * (`MFCR_CLK_HZ / 1000000)))

`endif

// ===== include/mfcr_pkg.sv
// Purpose: shared types of the modem front end register bank
// Assumes: nothing beyond the defines header
// Notes: types only; numbers live in mfcr_defines.svh
package mfcr_pkg;

   typedef enum logic [1:0] {
      MFCR_INTERP_NONE,
      MFCR_INTERP_LOWPASS,
      MFCR_INTERP_BANDPASS,
      MFCR_INTERP_UNDEFINED
   } mfcr_interp_t;

   // applied gain split between the two amplifier stages, in dB
   typedef struct packed {
      logic signed [7:0] total_db;
      logic [7:0] continuous_gain_stage_db;
      logic signed [7:0] switched_gain_stage_db;
   } mfcr_gain_t;

   typedef struct packed {
      logic lpf_bypass;
      logic one_pole;
      logic wideband;
      logic fast_adc;
      logic hpf_bypass;
      logic offset_busy;
      logic cal_busy;
   } mfcr_rx_ctrl_t;

   typedef struct packed {
      logic twos;
      logic sample_falling;
      mfcr_interp_t interp;
      logic half_rate_read;
   } mfcr_tx_ctrl_t;

   typedef struct packed {
      logic twos;
      logic output_falling;
      logic tristate;
      logic clka_off;
      logic clka_osc;
      logic clkb_off;
      logic clkb_div4;
   } mfcr_rx_output_clock_ctrl_t;

endpackage

// ===== hw/mfcr_gain_map.sv
// Purpose: maps a gain code onto the two amplifier stages
// Assumes: code already clamped to the legal range
// Notes: purely combinational
`timescale 1ns/1ps
`include "mfcr_defines.svh"
module mfcr_gain_map (
   input wire logic [4:0] i_code,
   input wire logic i_wideband,
   output mfcr_pkg::mfcr_gain_t o_gain
);
   import mfcr_pkg::*;

   wire [7:0] code8 = {3'h0, i_code};
   wire is_upper = (i_code >= `MFCR_GAIN_WIDE_CAP);
   wire [7:0] step_in_upper = code8 - {3'h0, `MFCR_GAIN_WIDE_CAP};
   // below 0x12 the continuous stage steps every three codes
   wire [7:0] cont_low = 8'h06 * ((code8 - 8'h03) / 8'h03);
   wire [7:0] sw_low = 8'h02 * (code8 % 8'h03);
   wire [7:0] cont_val = is_upper ? (i_wideband ? 8'h1e : 8'h18) : cont_low;
   wire [7:0] sw_val = is_upper ? (i_wideband ? 8'h02 * step_in_upper : 8'h06) : sw_low;

   assign o_gain.continuous_gain_stage_db = (code8 < 8'h06) ? 8'h00 : cont_val;
   assign o_gain.switched_gain_stage_db = (code8 < 8'h06) ? (8'h02 * code8 - 8'h06) : sw_val;
   assign o_gain.total_db = o_gain.continuous_gain_stage_db + o_gain.switched_gain_stage_db;
endmodule

// ===== hw/mfcr_regs.sv
// Purpose: configuration and status register bank of the modem front end digital section
// Assumes: the serial port decoder hands over single-byte reads and writes as one-cycle strobes
// Notes: analog effects leave as control levels; aux clocks are built from oscillator and pll enables
`timescale 1ns/1ps
`include "mfcr_defines.svh"
module mfcr_regs #(
   parameter int unsigned CAL_PERIOD_CYCLES = `MFCR_PERIOD_CYCLES,
   parameter int unsigned CAL_CYCLES = `MFCR_CAL_CYCLES,
   parameter int unsigned OFFSET_CYCLES = `MFCR_OFFSET_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   input wire logic [2:0] i_external_gain_pins,
   input wire logic i_rx_gain_boost_pin,
   input wire logic [1:0] i_pll_mult_sel,
   input wire logic i_osc_tick,
   input wire logic i_pll_tick,
   output mfcr_pkg::mfcr_rx_ctrl_t o_rx_ctrl,
   output logic [7:0] o_tune_target,
   output logic o_cal_start,
   output mfcr_pkg::mfcr_gain_t o_gain,
   output logic [4:0] o_gain_code,
   output mfcr_pkg::mfcr_tx_ctrl_t o_tx_ctrl,
   output logic [3:0] o_pll_mult,
   output mfcr_pkg::mfcr_rx_output_clock_ctrl_t o_rx_output_clock_ctrl,
   output logic o_rx_bus_oe,
   output logic o_aux_clk_a,
   output logic o_aux_clk_b
);
   import mfcr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   wire wr_fs = i_wr & hit(i_addr, `MFCR_OFS_FILTER_SEL);
   wire wr_tt = i_wr & hit(i_addr, `MFCR_OFS_TUNE_TARGET);
   wire wr_ga = i_wr & hit(i_addr, `MFCR_OFS_GAIN_ADJ);
   wire wr_tx = i_wr & hit(i_addr, `MFCR_OFS_TX_SET);
   wire wr_rc = i_wr & hit(i_addr, `MFCR_OFS_RX_CLK_SET);

   ////////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] filter_sel;
   logic [7:0] tune_target;
   logic [7:0] gain_adj;
   logic [7:0] tx_set;
   logic [7:0] rx_clk_set;

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         filter_sel <= `MFCR_RST_FILTER_SEL & `MFCR_FS_WR_MASK;
         tune_target <= `MFCR_RST_TUNE_TARGET;
         gain_adj <= `MFCR_RST_GAIN_ADJ;
         tx_set <= `MFCR_RST_TX_SET;
         rx_clk_set <= `MFCR_RST_RX_CLK_SET;
      end else begin
         // busy bits are not stored; a write to bit 6 vanishes, while a 1 written to bit 5 starts offset correction
         if (wr_fs) filter_sel <= i_wdata & `MFCR_FS_WR_MASK;
         if (wr_tt) tune_target <= i_wdata;
         if (wr_ga) gain_adj <= {i_wdata[`MFCR_GA_BOOST_INV], 1'b0, i_wdata[5:0]};
         if (wr_tx) tx_set <= i_wdata & `MFCR_TX_WR_MASK;
         if (wr_rc) rx_clk_set <= i_wdata & `MFCR_RX_WR_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // calibration sequencer
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} mfcr_cal_state_t;
   mfcr_cal_state_t cal_state;
   mfcr_cal_state_t next_cal_state;
   logic [31:0] cal_cnt;
   logic [31:0] period_cnt;
   logic cal_pending;

   wire upd_disable = filter_sel[`MFCR_FS_UPD_DISABLE];
   // a 0 written to the disable bit asks for an immediate run
   wire cal_kick = wr_fs & ~i_wdata[`MFCR_FS_UPD_DISABLE];
   wire period_due = ~upd_disable & (period_cnt >= CAL_PERIOD_CYCLES - 1);
   wire cal_done = (cal_state == CAL_RUN) & (cal_cnt >= CAL_CYCLES - 1);
   wire start_now = (cal_state == CAL_IDLE) & (cal_pending | cal_kick | period_due);

   always_comb begin
      next_cal_state = cal_state;
      unique case (cal_state)
         CAL_IDLE: begin
            if (start_now) next_cal_state = CAL_RUN;
         end
         CAL_RUN: begin
            if (cal_done) next_cal_state = CAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         cal_state <= CAL_IDLE;
         cal_pending <= 1'b1;
         cal_cnt <= 32'h0;
         period_cnt <= 32'h0;
      end else begin
         cal_state <= next_cal_state;
         // a kick during a run is remembered so it is not lost
         cal_pending <= (cal_state == CAL_RUN) & (cal_pending | cal_kick);
         cal_cnt <= (cal_state == CAL_RUN) ? cal_cnt + 32'h1 : 32'h0;
         period_cnt <= (start_now | upd_disable) ? 32'h0 : period_cnt + 32'h1;
      end
   end

   wire cal_busy = (cal_state == CAL_RUN);
   assign o_cal_start = start_now;

   ////////////////////////////////////////////////////////////////////////////
   // dc offset correction, self clearing
   logic [31:0] offset_cnt;
   logic offset_busy;
   wire offset_kick = wr_fs & i_wdata[`MFCR_FS_OFFSET_CORR];

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         offset_busy <= 1'b0;
         offset_cnt <= 32'h0;
      end else if (offset_kick) begin
         offset_busy <= 1'b1;
         offset_cnt <= 32'h0;
      end else if (offset_busy) begin
         offset_cnt <= offset_cnt + 32'h1;
         if (offset_cnt >= OFFSET_CYCLES - 1) offset_busy <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gain selection
   wire src_reg = gain_adj[`MFCR_GA_SRC_REG];
   wire boost_mapped = i_rx_gain_boost_pin ^ gain_adj[`MFCR_GA_BOOST_INV];
   // pins give 8 dB steps: three pins then boost on top
   // one spare bit: all pins plus boost exceed the five-bit code and must clamp, not wrap
   wire [5:0] pin_code = {1'b0, i_external_gain_pins, 2'h0} + {2'h0, boost_mapped, 3'h0};
   wire [5:0] raw_code = src_reg ? {1'b0, gain_adj[`MFCR_GA_GAIN_MSB:0]} : pin_code;
   wire [4:0] legal_code = (raw_code > {1'b0, `MFCR_GAIN_MAX}) ? `MFCR_GAIN_MAX : raw_code[4:0];
   wire wideband = filter_sel[`MFCR_FS_WIDEBAND];

   mfcr_gain_t gain_map;
   mfcr_gain_map u_gain_map (
      .i_code(legal_code),
      .i_wideband(wideband),
      .o_gain(gain_map)
   );

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_gain <= '0;
         o_gain_code <= 5'h00;
      end else begin
         o_gain <= gain_map;
         o_gain_code <= legal_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit and receive controls
   wire [3:0] interp_field = tx_set[7:`MFCR_TX_INTERP_LSB];
   wire is_lpf = (interp_field == `MFCR_INTERP_LPF);
   wire is_bpf = (interp_field == `MFCR_INTERP_BPF);
   wire is_byp = (interp_field == `MFCR_INTERP_BYPASS);
   wire [1:0] interp_sel = is_lpf ? 2'h1 : (is_bpf ? 2'h2 : (is_byp ? 2'h0 : 2'h3));

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_rx_ctrl <= '0;
         o_tx_ctrl <= '{twos: 1'b0, sample_falling: 1'b0, interp: MFCR_INTERP_LOWPASS, half_rate_read: 1'b1};
         o_rx_output_clock_ctrl <= '0;
         o_tune_target <= `MFCR_RST_TUNE_TARGET;
         o_pll_mult <= 4'h1;
      end else begin
         o_rx_ctrl.lpf_bypass <= filter_sel[`MFCR_FS_BYPASS];
         o_rx_ctrl.one_pole <= filter_sel[`MFCR_FS_ONE_POLE];
         o_rx_ctrl.wideband <= wideband;
         o_rx_ctrl.fast_adc <= filter_sel[`MFCR_FS_FAST_ADC];
         o_rx_ctrl.hpf_bypass <= filter_sel[`MFCR_FS_HPF_BYPASS];
         o_rx_ctrl.offset_busy <= offset_busy;
         o_rx_ctrl.cal_busy <= cal_busy;
         o_tune_target <= tune_target;
         o_tx_ctrl.twos <= tx_set[`MFCR_TX_TWOS];
         o_tx_ctrl.sample_falling <= tx_set[`MFCR_TX_FALL];
         o_tx_ctrl.interp <= mfcr_interp_t'(interp_sel);
         o_tx_ctrl.half_rate_read <= is_lpf | is_bpf;
         o_rx_output_clock_ctrl.twos <= rx_clk_set[`MFCR_RX_TWOS];
         o_rx_output_clock_ctrl.output_falling <= rx_clk_set[`MFCR_RX_FALL];
         o_rx_output_clock_ctrl.tristate <= rx_clk_set[`MFCR_RX_TRISTATE];
         o_rx_output_clock_ctrl.clka_off <= rx_clk_set[`MFCR_CKA_OFF];
         o_rx_output_clock_ctrl.clka_osc <= rx_clk_set[`MFCR_CKA_OSC];
         o_rx_output_clock_ctrl.clkb_off <= rx_clk_set[`MFCR_CKB_OFF];
         o_rx_output_clock_ctrl.clkb_div4 <= rx_clk_set[`MFCR_CKB_DIV4];
         o_pll_mult <= 4'h1 << i_pll_mult_sel;
      end
   end

   assign o_rx_bus_oe = ~o_rx_output_clock_ctrl.tristate;

   ////////////////////////////////////////////////////////////////////////////
   // auxiliary clocks, toggled by oscillator and pll rate enables
   logic [2:0] osc_div;
   logic clka_tgl;

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         osc_div <= 3'h0;
         clka_tgl <= 1'b0;
         o_aux_clk_a <= 1'b0;
         o_aux_clk_b <= 1'b0;
      end else begin
         if (i_osc_tick) osc_div <= osc_div + 3'h1;
         if (rx_clk_set[`MFCR_CKA_OSC] ? i_osc_tick : i_pll_tick) clka_tgl <= ~clka_tgl;
         // toggling on each tick gives half rate; ticks come at twice the named rate
         o_aux_clk_a <= ~rx_clk_set[`MFCR_CKA_OFF] & clka_tgl;
         o_aux_clk_b <= ~rx_clk_set[`MFCR_CKB_OFF]
                        & (rx_clk_set[`MFCR_CKB_DIV4] ? osc_div[2] : osc_div[1]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read back
   wire [7:0] fs_rd = filter_sel | {1'b0, cal_busy, offset_busy, 5'h00};
   wire [7:0] ga_rd = {gain_adj[`MFCR_GA_BOOST_INV], i_rx_gain_boost_pin, src_reg, legal_code};
   wire [7:0] rd_mux = hit(i_addr, `MFCR_OFS_FILTER_SEL) ? fs_rd :
                       hit(i_addr, `MFCR_OFS_TUNE_TARGET) ? tune_target :
                       hit(i_addr, `MFCR_OFS_GAIN_ADJ) ? ga_rd :
                       hit(i_addr, `MFCR_OFS_TX_SET) ? tx_set :
                       hit(i_addr, `MFCR_OFS_RX_CLK_SET) ? rx_clk_set :
                       hit(i_addr, `MFCR_OFS_REVISION) ? `MFCR_REVISION_CODE : 8'h00;

   always_ff @(posedge i_clock) begin
      if (!i_resetn) o_rdata <= 8'h00;
      else if (i_rd) o_rdata <= rd_mux;
   end
endmodule

// ===== bench/mfcr_regs_chk.sv
// Purpose: port-level assertions for the modem front end register bank
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound onto mfcr_regs at the foot of this file
`timescale 1ns/1ps
module mfcr_regs_chk (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic [1:0] i_pll_mult_sel,
   input wire mfcr_pkg::mfcr_rx_ctrl_t o_rx_ctrl,
   input wire logic o_cal_start,
   input wire mfcr_pkg::mfcr_gain_t o_gain,
   input wire logic [4:0] o_gain_code,
   input wire mfcr_pkg::mfcr_tx_ctrl_t o_tx_ctrl,
   input wire logic [3:0] o_pll_mult,
   input wire mfcr_pkg::mfcr_rx_output_clock_ctrl_t o_rx_output_clock_ctrl,
   input wire logic o_rx_bus_oe,
   input wire logic o_aux_clk_a,
   input wire logic o_aux_clk_b
);
   import mfcr_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   ////////////////////////////////////////////////////////////////////////////////
   a_rx_tristate: assert property (o_rx_bus_oe == !o_rx_output_clock_ctrl.tristate)
      else $error("rx bus driven while three-state set");
   a_clka_gate: assert property (o_rx_output_clock_ctrl.clka_off && $past(o_rx_output_clock_ctrl.clka_off) |-> !o_aux_clk_a)
      else $error("first aux clock not held low");
   a_clkb_gate: assert property (o_rx_output_clock_ctrl.clkb_off && $past(o_rx_output_clock_ctrl.clkb_off) |-> !o_aux_clk_b)
      else $error("second aux clock not held low");
   a_gain_split: assert property (o_gain.total_db == 8'(o_gain.continuous_gain_stage_db + o_gain.switched_gain_stage_db))
      else $error("stage gains do not add to total");
   // guarded by stability so a one-stage lag between code and gain is tolerated
   a_gain_code_map: assert property ($past(i_resetn) && $stable(o_gain_code) && o_gain_code <= 5'h11 |->
      o_gain.total_db == 8'(2 * o_gain_code - 6))
      else $error("gain code to dB mismatch");
   a_narrow_cap: assert property (!o_rx_ctrl.wideband && $past(!o_rx_ctrl.wideband) |-> $signed(o_gain.total_db) <= 30)
      else $error("gain above 30 dB without wideband");
   a_cal_run: assert property (o_cal_start |-> ##2 o_rx_ctrl.cal_busy [*8])
      else $error("calibration busy dropped early");
   a_pll_mult: assert property ($past(i_resetn) && $stable(i_pll_mult_sel) |-> o_pll_mult == 4'h1 << i_pll_mult_sel)
      else $error("multiplier decode wrong");
   a_interp_rate: assert property (o_tx_ctrl.half_rate_read ==
      (o_tx_ctrl.interp inside {MFCR_INTERP_LOWPASS, MFCR_INTERP_BANDPASS}))
      else $error("buffer read rate wrong");
   a_offset_start: assert property (i_wr && i_addr == 4'h4 && i_wdata[5] |-> ##[1:2] o_rx_ctrl.offset_busy)
      else $error("offset correction not started");
   a_unmapped_rd: assert property (i_rd && !(i_addr inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf}) |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind mfcr_regs mfcr_regs_chk u_chk (.i_clock(i_clock), .i_resetn(i_resetn), .i_wr(i_wr), .i_rd(i_rd),
   .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_pll_mult_sel(i_pll_mult_sel), .o_rx_ctrl(o_rx_ctrl),
   .o_cal_start(o_cal_start), .o_gain(o_gain), .o_gain_code(o_gain_code), .o_tx_ctrl(o_tx_ctrl),
   .o_pll_mult(o_pll_mult), .o_rx_output_clock_ctrl(o_rx_output_clock_ctrl), .o_rx_bus_oe(o_rx_bus_oe), .o_aux_clk_a(o_aux_clk_a),
   .o_aux_clk_b(o_aux_clk_b));

// ===== bench/mfcr_host.sv
// Purpose: serial port host model issuing single-byte register accesses
// Assumes: strobes change only at the falling clock edge
// Notes: also makes the oscillator and multiplied-clock ticks (multiplier of 2)
`timescale 1ns/1ps
module mfcr_host (
   input wire logic i_clock,
   input wire logic [7:0] i_rdata,
   output logic o_wr,
   output logic o_rd,
   output logic [3:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_osc_tick,
   output logic o_pll_tick
);
   logic [1:0] tick_cnt = 2'h0;
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 4'h0;
      o_wdata = 8'h00;
   end
   always @(negedge i_clock) tick_cnt <= tick_cnt + 2'h1;
   assign o_osc_tick = (tick_cnt == 2'h0);
   assign o_pll_tick = tick_cnt[0];
   ////////////////////////////////////////////////////////////////////////////////
   // released lines carry the inverse so a stale value never looks valid
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge i_clock);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clock);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge i_clock);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_clock);
      o_rd = 1'b0;
      o_addr = ~a;
      d = i_rdata;
   endtask
endmodule

// ===== bench/mfcr_regs_tb.sv
// Purpose: self-checking bench for the modem front end register bank
// Assumes: shortened calibration, period and offset counts
// Notes: all register traffic goes through the host model
`timescale 1ns/1ps
module mfcr_regs_tb;
   import mfcr_pkg::*;
   logic i_clock = 1'b0;
   logic i_resetn = 1'b0;
   logic [2:0] pins = 3'h0;
   logic boost = 1'b0;
   logic [1:0] mult_sel = 2'h0;
   logic wr, rd, osc_tick, pll_tick, cal_start, bus_oe, clk_a, clk_b;
   logic [3:0] addr, pll_mult;
   logic [7:0] wdata, rdata, tune;
   logic [4:0] code;
   mfcr_rx_ctrl_t rx_ctrl;
   mfcr_gain_t gain;
   mfcr_tx_ctrl_t tx_ctrl;
   mfcr_rx_output_clock_ctrl_t rx_output_clock;
   int fail_count = 0;
   int total_checks = 0;
   int cal_n = 0;
   always #5 i_clock = ~i_clock;
   always @(posedge i_clock) if (cal_start) cal_n++;
   mfcr_host u_host (.i_clock(i_clock), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
      .o_osc_tick(osc_tick), .o_pll_tick(pll_tick));
   mfcr_regs #(.CAL_PERIOD_CYCLES(2000), .CAL_CYCLES(50), .OFFSET_CYCLES(10)) u_dut (.i_clock(i_clock),
      .i_resetn(i_resetn), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
      .i_external_gain_pins(pins), .i_rx_gain_boost_pin(boost), .i_pll_mult_sel(mult_sel), .i_osc_tick(osc_tick),
      .i_pll_tick(pll_tick), .o_rx_ctrl(rx_ctrl), .o_tune_target(tune), .o_cal_start(cal_start), .o_gain(gain),
      .o_gain_code(code), .o_tx_ctrl(tx_ctrl), .o_pll_mult(pll_mult), .o_rx_output_clock_ctrl(rx_output_clock), .o_rx_bus_oe(bus_oe),
      .o_aux_clk_a(clk_a), .o_aux_clk_b(clk_b));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d, exp, "register read");
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   // rising edges of both aux clocks over a fixed window; counts allow one edge of phase slack
   task automatic aux_chk(input int ea, input int eb);
      int na, nb;
      logic pa, pb;
      na = 0;
      nb = 0;
      pa = clk_a;
      pb = clk_b;
      repeat (320) begin
         @(negedge i_clock);
         na += int'(clk_a && !pa);
         nb += int'(clk_b && !pb);
         pa = clk_a;
         pb = clk_b;
      end
      chk(8'(na >= ea - 1 && na <= ea + 1), 8'h01, "aux clock a rate");
      chk(8'(nb >= eb - 1 && nb <= eb + 1), 8'h01, "aux clock b rate");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #300000;
      fail_count++;
      $display("ERROR t=%0t watchdog expired", $time);
      end_sim;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [3:0] ra[8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf, 4'h3, 4'ha};
      logic [7:0] rv[8] = '{8'h80, 8'h80, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [3:0] icode[4] = '{4'h1, 4'h2, 4'h5, 4'h3};
      mfcr_interp_t iexp[4] = '{MFCR_INTERP_LOWPASS, MFCR_INTERP_NONE, MFCR_INTERP_BANDPASS, MFCR_INTERP_UNDEFINED};
      logic [7:0] v;
      int e, tot, n;
      repeat (6) @(negedge i_clock);
      i_resetn = 1'b1;
      idle(2);
      rchk(4'h4, 8'h41);
      u_host.wr(4'h4, 8'h80);
      idle(60);
      for (int i = 0; i < 8; i++) rchk(ra[i], rv[i]);
      u_host.wr(4'hf, 8'hff);
      u_host.wr(4'h2, 8'hff);
      rchk(4'hf, 8'h00);
      u_host.wr(4'h5, 8'h3c);
      rchk(4'h5, 8'h3c);
      chk(tune, 8'h3c, "tuning target");
      $display("test reset and identity done");
      for (int w = 0; w < 2; w++) begin
         u_host.wr(4'h4, w ? 8'hc4 : 8'h80);
         rchk(4'h4, w ? 8'h84 : 8'h80);
         for (int c = 0; c <= 'h17; c++) begin
            e = (c > 'h15) ? 'h15 : c;
            tot = (e > 'h11 && w == 0) ? 30 : 2 * e - 6;
            u_host.wr(4'h6, 8'(32 + c));
            rchk(4'h6, 8'(32 + e));
            chk(gain.total_db, 8'(tot), "applied gain");
         end
      end
      pins = 3'h3;
      boost = 1'b1;
      u_host.wr(4'h6, 8'h00);
      idle(3);
      rchk(4'h6, 8'h54);
      u_host.wr(4'h6, 8'h80);
      idle(3);
      rchk(4'h6, 8'hcc);
      chk(gain.total_db, 8'd18, "pin gain");
      pins = 3'h7;
      boost = 1'b0;
      idle(3);
      rchk(4'h6, 8'h95);
      $display("test gain done");
      for (int i = 0; i < 4; i++) begin
         u_host.wr(4'h7, {icode[i], 2'b00, 2'(i)});
         idle(1);
         chk({3'h0, tx_ctrl}, {3'h0, i[0], i[1], iexp[i], iexp[i] != MFCR_INTERP_NONE && i != 3}, "tx");
      end
      u_host.wr(4'h7, 8'hff);
      rchk(4'h7, 8'hf3);
      for (int i = 0; i < 8; i++) begin
         v = 8'h01 << i;
         u_host.wr(4'h8, v);
         idle(1);
         chk({1'b0, rx_output_clock}, {1'b0, v[0], v[1], v[3], v[4], v[6], v[5], v[7]}, "rx and clock");
         chk({7'h0, bus_oe}, {7'h0, !v[3]}, "rx bus enable");
         rchk(4'h8, v & 8'hfb);
      end
      $display("test transmit and receive settings done");
      for (int s = 0; s < 4; s++) begin
         mult_sel = 2'(s);
         idle(2);
         chk({4'h0, pll_mult}, 8'h01 << s, "multiplier");
      end
      mult_sel = 2'h1;
      u_host.wr(4'h8, 8'h00);
      idle(8);
      aux_chk(80, 20);
      u_host.wr(4'h8, 8'hc0);
      idle(8);
      aux_chk(40, 10);
      u_host.wr(4'h8, 8'h30);
      idle(8);
      aux_chk(0, 0);
      $display("test aux clocks done");
      u_host.wr(4'h4, 8'ha0);
      rchk(4'h4, 8'ha0);
      idle(12);
      rchk(4'h4, 8'h80);
      n = cal_n;
      u_host.wr(4'h4, 8'h00);
      rchk(4'h4, 8'h40);
      idle(4100);
      chk(8'(cal_n - n >= 2 && cal_n - n <= 3), 8'h01, "periodic calibration");
      u_host.wr(4'h4, 8'h80);
      idle(60);
      n = cal_n;
      idle(4100);
      chk(8'(cal_n - n), 8'h00, "calibration disabled");
      $display("test calibration done");
      i_resetn = 1'b0;
      idle(6);
      i_resetn = 1'b1;
      idle(2);
      rchk(4'h7, 8'h10);
      end_sim;
   end
endmodule
